/* rtl/addr_map_pkg.sv */
/*
  Constants shared by the memory addressing block: program counter width,
  vectors, data memory map and access kinds.
  Assumes nothing of its surroundings; imported by name only.
*/
package addr_map_pkg;

  localparam int          PC_W          = 11;
  localparam int          STACK_DEPTH   = 8;
  localparam logic [10:0] RESET_VECTOR  = 11'h000;
  localparam logic [10:0] SOFT_VECTOR   = 11'h001;
  localparam logic [10:0] HW_VECTOR     = 11'h008;
  localparam logic [10:0] ROLL_CODE_LO  = 11'h00E;
  localparam logic [10:0] ROLL_CODE_HI  = 11'h00F;
  localparam logic [10:0] RESERVED_LO   = 11'h7FE;
  localparam logic [6:0]  SFR_LAST      = 7'h1F;
  localparam logic [6:0]  RAM_FIRST     = 7'h20;
  localparam logic [6:0]  RAM_SPLIT     = 7'h40;
  localparam logic [6:0]  INDIRECT_ADDR = 7'h00;
  localparam logic [6:0]  POINTER_ADDR  = 7'h04;
  localparam logic [6:0]  STATUS_ADDR   = 7'h03;
  localparam int          BANK_HI_BIT   = 7;
  localparam int          BANK_LO_BIT   = 6;
  localparam logic [7:0]  STATUS_RESET  = 8'h00;
  localparam logic [7:0]  POINTER_RESET = 8'h00;
  localparam logic [1:0]  BANK0         = 2'h0;
  localparam logic [1:0]  BANK1         = 2'h1;
  localparam logic [1:0]  BANK2         = 2'h2;
  localparam logic [1:0]  BANK3         = 2'h3;

  typedef enum logic [3:0] {
    PC_STEP,
    PC_SHORT_JUMP,
    PC_SHORT_CALL,
    PC_LONG_JUMP,
    PC_LONG_CALL,
    PC_PLAIN_RETURN,
    PC_RETURN_LITERAL,
    PC_RETURN_INTERRUPT,
    PC_SOFT_INT,
    PC_HW_INT,
    PC_HOLD
  } pc_op_t;

  typedef enum logic [1:0] {
    PAGE_GENERAL,
    PAGE_PORT,
    PAGE_FUNCTION
  } page_t;

  typedef enum logic [1:0] {
    SPACE_NONE,
    SPACE_SFR,
    SPACE_RAM
  } space_t;

endpackage : addr_map_pkg

/* rtl/return_stack.sv */
/*
  Hardware return stack of program addresses with registered top output.
  Assumes the owner never pushes and pops in the same cycle.
*/
`timescale 1ns/1ns
module return_stack #(
  parameter int W     = 11,
  parameter int DEPTH = 8
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         clk_en,
  input  wire logic         push,
  input  wire logic         pop,
  input  wire logic [W-1:0] push_data,
  output logic      [W-1:0] top_data
);

  logic [W-1:0] mem_q [DEPTH];
  logic [W-1:0] mem_d [DEPTH];
  logic [W-1:0] top_d;
  logic [W-1:0] top_q;

  // A full stack wraps by shifting: the oldest entry falls off the bottom.
  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      mem_d[i] = mem_q[i];
    end
    if (push) begin
      mem_d[0] = push_data;
      for (int i = 1; i < DEPTH; i++) begin
        mem_d[i] = mem_q[i-1];
      end
    end else if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        mem_d[i] = mem_q[i+1];
      end
      mem_d[DEPTH-1] = mem_q[DEPTH-1];
    end
    top_d = mem_d[0];
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
      top_q <= '0;
    end else if (clk_en) begin
      mem_q <= mem_d;
      top_q <= top_d;
    end
  end

  assign top_data = top_q;

endmodule : return_stack

/* rtl/mem_addr_map.sv */
/*
  Program counter and data memory address formation for a small 8-bit core.
  Assumes the core decodes each instruction into one pc_op per cycle and
  presents data accesses with their page, opcode location and strobes.
*/
// Operation
// - Program counter is 11 bits wide, covering all 2K program words.
// - After reset the counter holds 0x000, the first fetch address.
// - A software interrupt loads the counter with 0x001.
// - Any hardware interrupt loads the counter with 0x008.
// - Short jump and short call take an 8-bit target, 256 locations.
// - Long jump and long call load any full 11-bit address.
// - Calls push the next program address; interrupt entry pushes the interrupted one.
// - All three return instructions pop the stack top into the counter.
// - Addresses 0x00E and 0x00F hold a rolling code, usable as code.
// - Data accesses split into general page, port page, function page.
// - Status bits 7 and 6 select one of four general-page banks.
// - Indirect access uses bank bits and file pointer bits 6 to 0.
// - Direct access uses bank bits and opcode bits 6 to 0.
// - General-page special registers serve ordinary instructions.
// - General-page special registers exist only at 0x00-0x1F, bank 0.
// - Banks 1 to 3 at 0x00-0x1F map onto the bank 0 registers.
// - RAM lives at 0x20-0x7F of bank 0 and 0x20-0x3F of bank 1.
// - Other banked RAM addresses alias onto present RAM.
// - Only their own instructions reach port page and function page.
// - Bank bits are ignored for port-page and function-page accesses.
`timescale 1ns/1ns
module mem_addr_map #(
  parameter int STACK_DEPTH = addr_map_pkg::STACK_DEPTH
) (
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  input  wire logic                 clk_en,
  input  addr_map_pkg::pc_op_t      pc_op,
  input  wire logic [10:0]          jump_target,
  input  wire logic                 acc_valid,
  input  addr_map_pkg::page_t       acc_page,
  input  wire logic [13:0]          opcode,
  input  wire logic                 acc_write,
  input  wire logic [7:0]           acc_wdata,
  output logic      [10:0]          fetch_addr,
  output logic      [10:0]          stack_top,
  output logic                      fetch_reserved,
  output logic                      fetch_roll_code,
  output logic      [1:0]           bank_sel,
  output logic      [7:0]           file_pointer,
  output logic                      sfr_sel,
  output logic      [4:0]           sfr_addr,
  output logic                      ram_sel,
  output logic                      ram_bank,
  output logic      [6:0]           ram_addr,
  output logic                      port_page_sel,
  output logic                      function_page_sel,
  output logic      [6:0]           special_page_addr,
  output logic                      acc_we
);

  // ****************************************************************
  // Program counter
  // ****************************************************************
  logic [10:0] pc_q;
  logic [10:0] pc_d;
  logic [10:0] pc_next_word;
  logic        push;
  logic        pop;

  always_comb begin
    pc_next_word = pc_q + 11'h001;
    pc_d         = pc_next_word;
    push         = 1'b0;
    pop          = 1'b0;
    case (pc_op)
      addr_map_pkg::PC_STEP: begin
        pc_d = pc_next_word;
      end
      addr_map_pkg::PC_SHORT_JUMP: begin
        pc_d = {3'h0, jump_target[7:0]};
      end
      addr_map_pkg::PC_SHORT_CALL: begin
        pc_d = {3'h0, jump_target[7:0]};
        push = 1'b1;
      end
      addr_map_pkg::PC_LONG_JUMP: begin
        pc_d = jump_target;
      end
      addr_map_pkg::PC_LONG_CALL: begin
        pc_d = jump_target;
        push = 1'b1;
      end
      addr_map_pkg::PC_PLAIN_RETURN,
      addr_map_pkg::PC_RETURN_LITERAL,
      addr_map_pkg::PC_RETURN_INTERRUPT: begin
        pc_d = stack_top;
        pop  = 1'b1;
      end
      addr_map_pkg::PC_SOFT_INT: begin
        // The interrupted word is re-fetched on return, so push pc_q.
        pc_d = addr_map_pkg::SOFT_VECTOR;
        push = 1'b1;
      end
      addr_map_pkg::PC_HW_INT: begin
        pc_d = addr_map_pkg::HW_VECTOR;
        push = 1'b1;
      end
      addr_map_pkg::PC_HOLD: begin
        pc_d = pc_q;
      end
      default: begin
        pc_d = pc_q;
      end
    endcase
  end

  logic [10:0] push_addr;

  // Calls push the word after the call; interrupts push the word not yet
  // executed.
  always_comb begin
    if (pc_op == addr_map_pkg::PC_SOFT_INT ||
        pc_op == addr_map_pkg::PC_HW_INT) begin
      push_addr = pc_q;
    end else begin
      push_addr = pc_next_word;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pc_q <= addr_map_pkg::RESET_VECTOR;
    end else if (clk_en) begin
      pc_q <= pc_d;
    end
  end

  // ****************************************************************
  // Return stack
  // ****************************************************************
  return_stack #(
    .W     (addr_map_pkg::PC_W),
    .DEPTH (STACK_DEPTH)
  ) u_stack (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .clk_en    (clk_en),
    .push      (push),
    .pop       (pop),
    .push_data (push_addr),
    .top_data  (stack_top)
  );

  assign fetch_addr = pc_q;

  // ****************************************************************
  // Fetch address flags
  // ****************************************************************
  logic reserved_q;
  logic reserved_d;
  logic roll_code_q;
  logic roll_code_d;

  // Flags only; the image is expected to keep clear of the top two words.
  // They are worked out from pc_d so that each stands, from a flip-flop,
  // in the same cycle as the fetch address it describes.
  always_comb begin
    reserved_d  = (pc_d >= addr_map_pkg::RESERVED_LO);
    roll_code_d = (pc_d == addr_map_pkg::ROLL_CODE_LO) ||
                  (pc_d == addr_map_pkg::ROLL_CODE_HI);
  end

  // The reset vector is neither reserved nor a rolling-code word.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reserved_q  <= 1'b0;
      roll_code_q <= 1'b0;
    end else if (clk_en) begin
      reserved_q  <= reserved_d;
      roll_code_q <= roll_code_d;
    end
  end

  assign fetch_reserved  = reserved_q;
  assign fetch_roll_code = roll_code_q;

  // ****************************************************************
  // Bank selector and file pointer shadows
  // ****************************************************************
  logic [1:0] bank_q;
  logic [1:0] bank_d;
  logic [7:0] ptr_q;
  logic [7:0] ptr_d;
  logic [6:0] loc;
  logic       general;
  logic       indirect;
  logic       hit_status;
  logic       hit_pointer;

  assign general  = acc_valid && (acc_page == addr_map_pkg::PAGE_GENERAL);
  assign indirect = (opcode[6:0] == addr_map_pkg::INDIRECT_ADDR);
  // A pointer that holds 0 lands on location 0 itself, which decodes as a
  // special register instead of chaining through the pointer again.
  assign loc      = indirect ? ptr_q[6:0] : opcode[6:0];

  // Status and pointer sit in the special-register window, so every bank
  // reaches them.
  assign hit_status  = general && (loc == addr_map_pkg::STATUS_ADDR);
  assign hit_pointer = general && (loc == addr_map_pkg::POINTER_ADDR);

  always_comb begin
    bank_d = bank_q;
    ptr_d  = ptr_q;
    if (acc_write && hit_status) begin
      bank_d = acc_wdata[addr_map_pkg::BANK_HI_BIT:
                         addr_map_pkg::BANK_LO_BIT];
    end
    if (acc_write && hit_pointer) begin
      ptr_d = acc_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bank_q <= addr_map_pkg::STATUS_RESET[7:6];
      ptr_q  <= addr_map_pkg::POINTER_RESET;
    end else if (clk_en) begin
      bank_q <= bank_d;
      ptr_q  <= ptr_d;
    end
  end

  assign bank_sel     = bank_q;
  assign file_pointer = ptr_q;

  // ****************************************************************
  // RAM bank aliasing
  // ****************************************************************
  logic low_ram;
  logic alias_bank;

  assign low_ram = (loc < addr_map_pkg::RAM_SPLIT);

  // Only bank 0 holds the upper RAM, so every bank folds onto it there;
  // the lower RAM exists twice and the odd banks reach the second copy.
  always_comb begin
    case (bank_q)
      addr_map_pkg::BANK0: begin
        alias_bank = 1'b0;
      end
      addr_map_pkg::BANK1: begin
        alias_bank = low_ram;
      end
      addr_map_pkg::BANK2: begin
        alias_bank = 1'b0;
      end
      addr_map_pkg::BANK3: begin
        alias_bank = low_ram;
      end
      default: begin
        alias_bank = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // Data address decode
  // ****************************************************************
  always_comb begin
    sfr_sel           = 1'b0;
    sfr_addr          = loc[4:0];
    ram_sel           = 1'b0;
    ram_bank          = 1'b0;
    ram_addr          = loc;
    port_page_sel     = 1'b0;
    function_page_sel = 1'b0;
    special_page_addr = opcode[6:0];
    if (acc_valid) begin
      case (acc_page)
        addr_map_pkg::PAGE_GENERAL: begin
          if (loc <= addr_map_pkg::SFR_LAST) begin
            sfr_sel = 1'b1;
          end else begin
            ram_sel  = 1'b1;
            ram_bank = alias_bank;
          end
        end
        addr_map_pkg::PAGE_PORT: begin
          port_page_sel = 1'b1;
        end
        addr_map_pkg::PAGE_FUNCTION: begin
          function_page_sel = 1'b1;
        end
        default: begin
          sfr_sel = 1'b0;
        end
      endcase
    end
  end

  assign acc_we = acc_valid && acc_write;

endmodule : mem_addr_map

/* test/mem_addr_map_monitor.sv */
/* Checker of program counter and data map relations at the ports.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ns
module mem_addr_map_monitor (
  input wire logic            clk,
  input wire logic            sys_rst,
  input wire logic            clk_en,
  input addr_map_pkg::pc_op_t pc_op,
  input wire logic [10:0]     jump_target,
  input wire logic            acc_valid,
  input addr_map_pkg::page_t  acc_page,
  input wire logic [13:0]     opcode,
  input wire logic [10:0]     fetch_addr,
  input wire logic [10:0]     stack_top,
  input wire logic [1:0]      bank_sel,
  input wire logic            sfr_sel,
  input wire logic [4:0]      sfr_addr,
  input wire logic            ram_sel,
  input wire logic            ram_bank,
  input wire logic [6:0]      ram_addr,
  input wire logic [7:0]      file_pointer,
  input wire logic            port_page_sel,
  input wire logic [6:0]      special_page_addr
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic       gen;
  logic [6:0] loc;
  assign gen = acc_valid && acc_page == addr_map_pkg::PAGE_GENERAL;
  assign loc = opcode[6:0];
  sequence call_taken;
    clk_en && pc_op inside {addr_map_pkg::PC_LONG_CALL,
                            addr_map_pkg::PC_SHORT_CALL};
  endsequence
  sequence ret_taken;
    clk_en && pc_op inside {addr_map_pkg::PC_PLAIN_RETURN,
      addr_map_pkg::PC_RETURN_LITERAL, addr_map_pkg::PC_RETURN_INTERRUPT};
  endsequence
  a_reset_vector: assert property (disable iff (1'b0) sys_rst |=>
    fetch_addr == 11'h000 && bank_sel == 2'h0) else $error("reset state");
  a_soft_vector: assert property (clk_en &&
    pc_op == addr_map_pkg::PC_SOFT_INT |=> fetch_addr == 11'h001)
    else $error("soft vector");
  a_hw_vector: assert property (clk_en &&
    pc_op == addr_map_pkg::PC_HW_INT |=> fetch_addr == 11'h008 &&
    stack_top == $past(fetch_addr)) else $error("hardware vector");
  a_short_reach: assert property (clk_en && pc_op inside
    {addr_map_pkg::PC_SHORT_JUMP, addr_map_pkg::PC_SHORT_CALL} |=>
    fetch_addr == {3'h0, $past(jump_target[7:0])}) else $error("short");
  a_long_reach: assert property (clk_en && pc_op inside
    {addr_map_pkg::PC_LONG_JUMP, addr_map_pkg::PC_LONG_CALL} |=>
    fetch_addr == $past(jump_target)) else $error("long target");
  a_call_push: assert property (call_taken |=>
    stack_top == $past(fetch_addr) + 11'h001) else $error("call push");
  a_return_pop: assert property (ret_taken |=>
    fetch_addr == $past(stack_top)) else $error("return pop");
  a_sfr_mirror: assert property (gen && loc != 7'h00 &&
    loc <= 7'h1F |-> sfr_sel && !ram_sel && sfr_addr == loc[4:0])
    else $error("special register mirror");
  a_ram_alias: assert property (gen && loc >= 7'h20 |->
    ram_sel && ram_addr == loc && ram_bank == (loc < 7'h40 &&
    bank_sel[0])) else $error("ram alias");
  a_indirect_loc: assert property (gen && loc == 7'h00 &&
    file_pointer[6:0] >= 7'h20 |-> ram_sel &&
    ram_addr == file_pointer[6:0]) else $error("indirect location");
  a_page_ignore: assert property (acc_valid &&
    acc_page == addr_map_pkg::PAGE_PORT |-> port_page_sel && !ram_sel &&
    !sfr_sel && special_page_addr == loc) else $error("port page");
endmodule : mem_addr_map_monitor
bind mem_addr_map mem_addr_map_monitor mem_addr_map_monitor_i (
  .clk, .sys_rst, .clk_en, .pc_op, .jump_target, .acc_valid, .acc_page,
  .opcode, .fetch_addr, .stack_top, .bank_sel, .sfr_sel, .sfr_addr,
  .ram_sel, .ram_bank, .ram_addr, .file_pointer, .port_page_sel,
  .special_page_addr);

/* test/core_model.sv */
/* Behavioural core decode stage driving PC operations and accesses.
   Assumes the bench calls its tasks from one thread. */
`timescale 1ns/1ns
module core_model (
  input  wire logic           clk,
  output addr_map_pkg::pc_op_t pc_op,
  output logic [10:0]         jump_target,
  output logic                acc_valid,
  output addr_map_pkg::page_t acc_page,
  output logic [13:0]         opcode,
  output logic                acc_write,
  output logic [7:0]          acc_wdata
);
  initial begin
    pc_op = addr_map_pkg::PC_HOLD;
    jump_target = 11'h000;
    acc_valid = 1'b0;
    acc_page = addr_map_pkg::PAGE_GENERAL;
    opcode = 14'h0000;
    acc_write = 1'b0;
    acc_wdata = 8'h00;
  end
  // Exactly one rising edge sees the operation; the caller then samples.
  task automatic issue(input addr_map_pkg::pc_op_t o, input logic [10:0] t);
    @(negedge clk);
    pc_op = o;
    jump_target = t;
    @(posedge clk);
    #1;
  endtask : issue
  // Decode is combinational, so outputs are sampled before the next edge.
  task automatic access(input addr_map_pkg::page_t p, input logic [6:0] l,
                        input logic w, input logic [7:0] d);
    @(negedge clk);
    acc_valid = 1'b1;
    acc_page = p;
    opcode = {7'h00, l};
    acc_write = w;
    acc_wdata = d;
    #10;
  endtask : access
endmodule : core_model

/* test/mem_addr_map_tb_top.sv */
/* Self-checking bench for mem_addr_map against a reference PC and stack.
   Assumes a 100 ns clock and the core model as the only driver of ops. */
`timescale 1ns/1ns
module mem_addr_map_tb_top;
  logic                 clk, sys_rst, clk_en, acc_valid, acc_write, acc_we;
  logic                 fetch_reserved, fetch_roll_code, sfr_sel, ram_sel;
  logic                 ram_bank, port_page_sel, function_page_sel;
  addr_map_pkg::pc_op_t pc_op;
  addr_map_pkg::page_t  acc_page;
  logic [13:0]          opcode;
  logic [10:0]          jump_target, fetch_addr, stack_top, ref_pc;
  logic [10:0]          stk [8];
  logic [7:0]           acc_wdata, file_pointer, ref_fp;
  logic [6:0]           ram_addr, special_page_addr;
  logic [4:0]           sfr_addr;
  logic [1:0]           bank_sel, ref_bank;
  int                   mismatches, check_count;
  mem_addr_map mem_addr_map_i (.clk, .sys_rst, .clk_en, .pc_op,
    .jump_target, .acc_valid, .acc_page, .opcode, .acc_write, .acc_wdata,
    .fetch_addr, .stack_top, .fetch_reserved, .fetch_roll_code, .bank_sel,
    .file_pointer, .sfr_sel, .sfr_addr, .ram_sel, .ram_bank, .ram_addr,
    .port_page_sel, .function_page_sel, .special_page_addr, .acc_we);
  core_model core_model_i (.clk, .pc_op, .jump_target, .acc_valid,
    .acc_page, .opcode, .acc_write, .acc_wdata);
  always #50 clk = ~clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  function automatic logic [10:0] pred(addr_map_pkg::pc_op_t o,
                                       logic [10:0] t);
    case (o)
      addr_map_pkg::PC_STEP: return ref_pc + 11'h001;
      addr_map_pkg::PC_SHORT_JUMP, addr_map_pkg::PC_SHORT_CALL:
        return {3'h0, t[7:0]};
      addr_map_pkg::PC_LONG_JUMP, addr_map_pkg::PC_LONG_CALL: return t;
      addr_map_pkg::PC_SOFT_INT: return 11'h001;
      addr_map_pkg::PC_HW_INT: return 11'h008;
      addr_map_pkg::PC_HOLD: return ref_pc;
      default: return stk[0];
    endcase
  endfunction : pred
  task automatic push(input logic [10:0] v);
    for (int i = 7; i > 0; i--) stk[i] = stk[i-1];
    stk[0] = v;
  endtask : push
  task automatic op(input addr_map_pkg::pc_op_t o, input logic [10:0] t);
    logic [10:0] e;
    e = pred(o, t);
    if (clk_en) begin
      if (o inside {addr_map_pkg::PC_SHORT_CALL, addr_map_pkg::PC_LONG_CALL})
        push(ref_pc + 11'h001);
      else if (o inside {addr_map_pkg::PC_SOFT_INT, addr_map_pkg::PC_HW_INT})
        push(ref_pc);
      else if (o inside {addr_map_pkg::PC_PLAIN_RETURN,
               addr_map_pkg::PC_RETURN_LITERAL,
               addr_map_pkg::PC_RETURN_INTERRUPT}) begin
        // A pop keeps the bottom entry, so an emptied stack repeats it.
        for (int i = 0; i < 7; i++) stk[i] = stk[i+1];
      end
      ref_pc = e;
    end
    core_model_i.issue(o, t);
    chk(fetch_addr, ref_pc);
    chk(stack_top, stk[0]);
    chk(fetch_reserved, ref_pc >= 11'h7FE);
  endtask : op
  task automatic acc(input addr_map_pkg::page_t p, input logic [6:0] l,
                     input logic w, input logic [7:0] d);
    logic [6:0] x;
    x = (l != 7'h00) ? l : ref_fp[6:0];
    core_model_i.access(p, l, w, d);
    chk(bank_sel, ref_bank);
    chk(file_pointer, ref_fp);
    chk(acc_we, w);
    if (p == addr_map_pkg::PAGE_GENERAL) begin
      chk(sfr_sel, x <= 7'h1F);
      chk(ram_sel, x > 7'h1F);
      if (x > 7'h1F) begin
        chk(ram_addr, x);
        chk(ram_bank, x < 7'h40 && ref_bank[0]);
      end else
        chk(sfr_addr, x[4:0]);
      if (w && x == 7'h03) ref_bank = d[7:6];
      if (w && x == 7'h04) ref_fp = d;
    end else begin
      chk(port_page_sel, p == addr_map_pkg::PAGE_PORT);
      chk(function_page_sel, p == addr_map_pkg::PAGE_FUNCTION);
      chk(ram_sel | sfr_sel, 1'b0);
      chk(special_page_addr, l);
    end
  endtask : acc
  task automatic do_reset;
    @(negedge clk);
    sys_rst = 1'b1;
    repeat (3) @(negedge clk);
    ref_pc = 11'h000;
    ref_bank = 2'h0;
    ref_fp = 8'h00;
    foreach (stk[i]) stk[i] = 11'h000;
    chk(fetch_addr, 11'h000);
    chk(bank_sel, 2'h0);
    sys_rst = 1'b0;
  endtask : do_reset
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    clk_en = 1'b1;
    mismatches = 0;
    check_count = 0;
    void'($urandom(32'hC51E));
    do_reset();
    op(addr_map_pkg::PC_LONG_CALL, 11'h123);
    op(addr_map_pkg::PC_SOFT_INT, 11'h000);
    op(addr_map_pkg::PC_HW_INT, 11'h000);
    op(addr_map_pkg::PC_RETURN_INTERRUPT, 11'h000);
    op(addr_map_pkg::PC_RETURN_LITERAL, 11'h000);
    op(addr_map_pkg::PC_SHORT_CALL, 11'h7AB);
    op(addr_map_pkg::PC_PLAIN_RETURN, 11'h000);
    op(addr_map_pkg::PC_LONG_JUMP, 11'h00E);
    chk(fetch_roll_code, 1'b1);
    op(addr_map_pkg::PC_STEP, 11'h000);
    op(addr_map_pkg::PC_STEP, 11'h000);
    chk(fetch_roll_code, 1'b0);
    for (int i = 0; i < 9; i++) op(addr_map_pkg::PC_LONG_CALL, 11'(i * 200));
    for (int i = 0; i < 10; i++) op(addr_map_pkg::PC_PLAIN_RETURN, 11'h000);
    clk_en = 1'b0;
    op(addr_map_pkg::PC_LONG_JUMP, 11'h3C3);
    clk_en = 1'b1;
    // Targets stay below the two reserved top words.
    repeat (300) op(addr_map_pkg::pc_op_t'($urandom % 11),
                    11'($urandom % 32'h7FE));
    op(addr_map_pkg::PC_HOLD, 11'h000);
    for (int b = 0; b < 4; b++) begin
      acc(addr_map_pkg::PAGE_GENERAL, 7'h03, 1'b1, {b[1:0], 6'h15});
      foreach (stk[i]) acc(addr_map_pkg::PAGE_GENERAL,
                           7'($urandom) | 7'h01, 1'b0, 8'h00);
      acc(addr_map_pkg::PAGE_GENERAL, 7'h1F, 1'b0, 8'h00);
      acc(addr_map_pkg::PAGE_GENERAL, 7'h20, 1'b0, 8'h00);
      acc(addr_map_pkg::PAGE_GENERAL, 7'h3F, 1'b0, 8'h00);
      acc(addr_map_pkg::PAGE_GENERAL, 7'h40, 1'b0, 8'h00);
    end
    acc(addr_map_pkg::PAGE_GENERAL, 7'h04, 1'b1, 8'hA5);
    acc(addr_map_pkg::PAGE_GENERAL, 7'h00, 1'b0, 8'h00);
    acc(addr_map_pkg::PAGE_PORT, 7'h03, 1'b1, 8'h00);
    acc(addr_map_pkg::PAGE_FUNCTION, 7'h15, 1'b0, 8'h00);
    acc(addr_map_pkg::PAGE_GENERAL, 7'h25, 1'b0, 8'h00);
    do_reset();
    op(addr_map_pkg::PC_STEP, 11'h000);
    acc(addr_map_pkg::PAGE_GENERAL, 7'h25, 1'b0, 8'h00);
    test_done();
  end
  initial begin
    #10000000;
    mismatches++;
    test_done();
  end
endmodule : mem_addr_map_tb_top
